// *** core/pick_copy_defines.svh ***
`ifndef PICK_COPY_DEFINES_SVH
`define PICK_COPY_DEFINES_SVH

// Register byte offsets
`define OFS_CMD 5'h00
`define OFS_STATUS 5'h04
`define OFS_PEN 5'h08
`define OFS_BLKSZ 5'h0C
`define OFS_CONFIG 5'h10

// Reset values
`define PEN_RST 32'h00000000
`define BLKSZ_RST 32'h00000000
`define CONFIG_RST 32'h000F0000

// Config fields
`define CFG_SEARCH_LO 0
`define CFG_FONT_LO 8
`define CFG_ACTIVE_LO 16

// Status fields
`define STAT_BUSY 0
`define STAT_PICK 1
`define STAT_CLIP 2

// Instruction word decode
`define OP_PICK 7'h35
`define OP_CLIP 7'h34
`define OP_COPY 7'h5C
`define OP_COPY_CUR 7'h1C
`define FLAG_BIT 7
`define SP_BIT 15
`define SI_BIT 14
`define M_BIT 13
`define CMB_LO 8
`define REL_BIT 15

// Cycle costs at ref_clk_i
`define PICK_CYC 9'h028
`define CLIP_CYC 9'h02D
`define COPY_SETUP 9'h0DA
`define CUR_SETUP 9'h0A6
`define LINE_PLAIN 9'h024
`define LINE_SP 9'h02A
`define LINE_INV 9'h028
`define LINE_MATCH 9'h028
`define WORD_PLAIN 9'h013
`define WORD_SP 9'h019
`define WORD_INV 9'h01E
`define WORD_MATCH 9'h114

`endif

// *** core/pick_copy_pkg.sv ***
package pick_copy_pkg;

	// Execution phases
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_PARAM = 3'h1,
		ST_FIXED = 3'h2,
		ST_SETUP = 3'h3,
		ST_LINE = 3'h4,
		ST_WORD = 3'h5
	} exec_state_t;

	// Combine operations, source S over destination D
	typedef enum logic [2:0] {
		CMB_ZERO = 3'h0,
		CMB_AND = 3'h1,
		CMB_OR = 3'h2,
		CMB_XOR = 3'h3,
		CMB_DST = 3'h4,
		CMB_SET = 3'h5,
		CMB_ANDNOT = 3'h6,
		CMB_ONES = 3'h7
	} combine_op_t;

	typedef logic [15:0] coord_t;

endpackage : pick_copy_pkg

// *** core/word_combine.sv ***
`timescale 1ns/10ps
module word_combine
	import pick_copy_pkg::*;
(
	input logic [63:0] src_i,
	input logic [63:0] dst_i,
	input combine_op_t op_i,
	output logic [63:0] res_o
);

	always_comb begin
		case (op_i)
			CMB_ZERO: res_o = 64'h0000000000000000;
			CMB_AND: res_o = src_i & dst_i;
			CMB_OR: res_o = src_i | dst_i;
			CMB_XOR: res_o = src_i ^ dst_i;
			CMB_DST: res_o = dst_i;
			CMB_SET: res_o = src_i;
			CMB_ANDNOT: res_o = ~src_i & dst_i;
			CMB_ONES: res_o = 64'hFFFFFFFFFFFFFFFF;
			default: res_o = dst_i;
		endcase
	end

endmodule : word_combine

// *** core/pick_copy_exec.sv ***
`timescale 1ns/10ps
`include "pick_copy_defines.svh"
module pick_copy_exec
	import pick_copy_pkg::*;
(
	input logic ref_clk_i,
	input logic rst_n_i,
	input logic [4:0] s_axi_awaddr_i,
	input logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input logic [31:0] s_axi_wdata_i,
	input logic [3:0] s_axi_wstrb_i,
	input logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input logic s_axi_bready_i,
	input logic [4:0] s_axi_araddr_i,
	input logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input logic s_axi_rready_i,
	output logic mem_re_o,
	output logic mem_we_o,
	output logic [15:0] mem_addr_o,
	output logic [63:0] mem_wdata_o,
	output logic [63:0] mem_wmask_o,
	input logic [63:0] mem_rdata_i,
	output logic pick_enable_o,
	output logic clip_enable_o
);

	logic rst_meta_r, rst_n;
	logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [4:0] aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt;
	logic [3:0] w_strb_r, w_strb_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	coord_t pen_x_r, pen_x_nxt, pen_y_r, pen_y_nxt;
	logic [31:0] blksz_r, blksz_nxt, config_r, config_nxt;
	logic cmd_valid, cmd_take, wr_go, busy, pen_ld_c, done_c, ld_c;
	logic [15:0] cmd_word;
	exec_state_t state_r, state_nxt;
	logic [15:0] instr_r, instr_nxt;
	logic [15:0] par_r [0:3];
	logic [15:0] par_nxt [0:3];
	logic [1:0] pidx_r, pidx_nxt;
	coord_t src_x_r, src_x_nxt, src_y_r, src_y_nxt, dst_x_r, dst_x_nxt, dst_y_r, dst_y_nxt;
	logic [10:0] row_r, row_nxt;
	logic [11:0] wd_r, wd_nxt;
	logic [8:0] tmr_r, tmr_nxt, pcnt_r, pcnt_nxt;
	logic [2:0] step_r, step_nxt;
	logic [63:0] srca_r, srca_nxt, srcb_r, srcb_nxt;
	logic mem_re_r, mem_re_nxt, mem_we_r, mem_we_nxt;
	logic [15:0] mem_addr_r, mem_addr_nxt;
	logic [63:0] mem_wdata_r, mem_wdata_nxt, mem_wmask_r, mem_wmask_nxt;
	logic pick_en_r, pick_en_nxt, clip_en_r, clip_en_nxt;

	// Reset release through two flops
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	// Byte lane merge
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = din[8*b +: 8];
			end
		end
		return res;
	endfunction : merge

	function automatic coord_t resolve(input coord_t base, input logic [15:0] w, input logic rel);
		return rel ? 16'(base + {{2{w[13]}}, w[13:0]}) : {2'h0, w[13:0]};
	endfunction : resolve

	// Bus handshakes
	assign cmd_word = w_data_r[15:0];
	assign busy = (state_r != ST_IDLE);
	assign cmd_valid = aw_held_r && w_held_r && !bvalid_r && ({aw_addr_r[4:2], 2'h0} == `OFS_CMD);
	assign wr_go = aw_held_r && w_held_r && !bvalid_r &&
		(({aw_addr_r[4:2], 2'h0} != `OFS_CMD) || cmd_take);
	assign s_axi_awready_o = !aw_held_r && !bvalid_r;
	assign s_axi_wready_o = !w_held_r && !bvalid_r;
	assign s_axi_arready_o = !rvalid_r;

	// Bus slave and software registers
	always_comb begin
		aw_held_nxt = aw_held_r;
		aw_addr_nxt = aw_addr_r;
		w_held_nxt = w_held_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		pen_x_nxt = pen_x_r;
		pen_y_nxt = pen_y_r;
		blksz_nxt = blksz_r;
		config_nxt = config_r;
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_held_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_held_nxt = 1'b1;
			w_data_nxt = s_axi_wdata_i;
			w_strb_nxt = s_axi_wstrb_i;
		end
		if (bvalid_r && s_axi_bready_i) begin
			bvalid_nxt = 1'b0;
		end
		if (wr_go) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = 2'h0;
			case ({aw_addr_r[4:2], 2'h0})
				`OFS_CMD: ;
				`OFS_STATUS: ;
				`OFS_PEN: begin
					if (!busy) begin
						{pen_y_nxt, pen_x_nxt} = merge({pen_y_r, pen_x_r}, w_data_r, w_strb_r);
					end
				end
				`OFS_BLKSZ: blksz_nxt = merge(blksz_r, w_data_r, w_strb_r);
				`OFS_CONFIG: config_nxt = merge(config_r, w_data_r, w_strb_r);
				default: bresp_nxt = 2'h2;
			endcase
		end
		if (pen_ld_c) begin
			pen_x_nxt = src_x_r;
			pen_y_nxt = src_y_r;
		end
		if (rvalid_r && s_axi_rready_i) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = 2'h0;
			case ({s_axi_araddr_i[4:2], 2'h0})
				`OFS_CMD: rdata_nxt = {16'h0000, instr_r};
				`OFS_STATUS: rdata_nxt = {29'h00000000, clip_en_r, pick_en_r, busy};
				`OFS_PEN: rdata_nxt = {pen_y_r, pen_x_r};
				`OFS_BLKSZ: rdata_nxt = blksz_r;
				`OFS_CONFIG: rdata_nxt = config_r;
				default: begin
					rdata_nxt = 32'h00000000;
					rresp_nxt = 2'h2;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 5'h00;
			w_held_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= 2'h0;
			{pen_y_r, pen_x_r} <= `PEN_RST;
			blksz_r <= `BLKSZ_RST;
			config_r <= `CONFIG_RST;
		end else begin
			aw_held_r <= aw_held_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_held_r <= w_held_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			pen_x_r <= pen_x_nxt;
			pen_y_r <= pen_y_nxt;
			blksz_r <= blksz_nxt;
			config_r <= config_nxt;
		end
	end

	// Instruction fields and phase costs
	logic is_full_c, sp_c, si_c, m_c, down_c, rtl_c;
	logic [1:0] last_c, font_c;
	logic [3:0] search_c, active_c;
	logic [8:0] setup_c, line_c, word_c;
	logic [10:0] bw_c, bh_c, roff_c;
	coord_t rsx_c, rsy_c, rdx_c, rdy_c, dend_c, pbase_c, sp_pix_c, srow_c, drow_c;
	logic [15:0] dwx_c, dwy_c;
	logic [11:0] wstart_c, wstop_c, swa_c;
	logic [15:0] inr_c, match_c;
	logic [15:0] raw_c [0:3];
	logic [63:0] src_eff_c, mask_c, comb_res_c;
	assign is_full_c = (instr_r[6:0] == `OP_COPY);
	assign sp_c = instr_r[`SP_BIT];
	assign si_c = instr_r[`SI_BIT];
	assign m_c = instr_r[`M_BIT];
	assign last_c = is_full_c ? 2'h3 : 2'h1;
	assign search_c = config_r[`CFG_SEARCH_LO +: 4];
	assign font_c = config_r[`CFG_FONT_LO +: 2];
	assign active_c = config_r[`CFG_ACTIVE_LO +: 4];
	assign bw_c = blksz_r[10:0];
	assign bh_c = blksz_r[26:16];
	assign setup_c = is_full_c ? `COPY_SETUP : `CUR_SETUP;
	assign line_c = sp_c ? `LINE_SP : (si_c ? `LINE_INV : (m_c ? `LINE_MATCH : `LINE_PLAIN));
	assign word_c = m_c ? `WORD_MATCH : (si_c ? `WORD_INV : (sp_c ? `WORD_SP : `WORD_PLAIN));

	// source from pen, destination from source
	assign rsx_c = is_full_c ? resolve(pen_x_r, par_r[0], par_r[0][`REL_BIT]) : pen_x_r;
	assign rsy_c = is_full_c ? resolve(pen_y_r, par_r[1], par_r[0][`REL_BIT]) : pen_y_r;
	assign dwx_c = is_full_c ? par_r[2] : par_r[0];
	assign dwy_c = is_full_c ? par_r[3] : par_r[1];
	assign rdx_c = resolve(rsx_c, dwx_c, dwx_c[`REL_BIT]);
	assign rdy_c = resolve(rsy_c, dwy_c, dwx_c[`REL_BIT]);

	assign down_c = ($signed(dst_y_r) <= $signed(src_y_r));
	assign rtl_c = ($signed(dst_x_r) > $signed(src_x_r));
	assign roff_c = down_c ? row_r : 11'(bh_c - 11'h001 - row_r);
	assign srow_c = 16'(src_y_r + {5'h00, roff_c});
	assign drow_c = 16'(dst_y_r + {5'h00, roff_c});
	assign dend_c = 16'(dst_x_r + {5'h00, bw_c} - 16'h0001);
	assign wstart_c = rtl_c ? dend_c[15:4] : dst_x_r[15:4];
	assign wstop_c = rtl_c ? dst_x_r[15:4] : dend_c[15:4];
	assign pbase_c = {wd_r, 4'h0};
	assign sp_pix_c = 16'(pbase_c + src_x_r - dst_x_r);
	assign swa_c = sp_pix_c[15:4];

	// Per pixel range and colour match
	for (genvar i = 0; i < 16; i++) begin : g_pix
		wire [15:0] pix = 16'(pbase_c + 16'(i));
		assign inr_c[i] = ($signed(pix) >= $signed(dst_x_r)) && ($signed(pix) <= $signed(dend_c));
		assign match_c[i] = ({mem_rdata_i[48+i], mem_rdata_i[32+i], mem_rdata_i[16+i],
			mem_rdata_i[i]} == search_c);
	end

	// Per plane source alignment and write mask
	for (genvar p = 0; p < 4; p++) begin : g_plane
		assign raw_c[p] = 16'({srcb_r[16*p +: 16], srca_r[16*p +: 16]} >> sp_pix_c[3:0]);
		assign src_eff_c[16*p +: 16] = (sp_c ? raw_c[font_c] : raw_c[p]) ^ {16{si_c}};
		assign mask_c[16*p +: 16] = {16{active_c[p]}} & inr_c & (m_c ? match_c : 16'hFFFF);
	end

	word_combine u_combine (
		.src_i(src_eff_c),
		.dst_i(mem_rdata_i),
		.op_i(combine_op_t'(instr_r[`CMB_LO +: 3])),
		.res_o(comb_res_c)
	);

	// Instruction sequencer and display memory port
	always_comb begin
		state_nxt = state_r;
		instr_nxt = instr_r;
		par_nxt = par_r;
		pidx_nxt = pidx_r;
		src_x_nxt = src_x_r;
		src_y_nxt = src_y_r;
		dst_x_nxt = dst_x_r;
		dst_y_nxt = dst_y_r;
		row_nxt = row_r;
		wd_nxt = wd_r;
		tmr_nxt = (tmr_r != 9'h000) ? 9'(tmr_r - 9'h001) : tmr_r;
		step_nxt = (step_r != 3'h5) ? 3'(step_r + 3'h1) : step_r;
		srca_nxt = srca_r;
		srcb_nxt = srcb_r;
		mem_re_nxt = 1'b0;
		mem_we_nxt = 1'b0;
		mem_addr_nxt = mem_addr_r;
		mem_wdata_nxt = mem_wdata_r;
		mem_wmask_nxt = mem_wmask_r;
		pick_en_nxt = pick_en_r;
		clip_en_nxt = clip_en_r;
		cmd_take = 1'b0;
		ld_c = 1'b0;
		done_c = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (cmd_valid) begin
					cmd_take = 1'b1;
					instr_nxt = cmd_word;
					pidx_nxt = 2'h0;
					case (cmd_word[6:0])
						`OP_PICK: begin
							pick_en_nxt = cmd_word[`FLAG_BIT];
							state_nxt = ST_FIXED;
							tmr_nxt = `PICK_CYC - 9'h002;
							ld_c = 1'b1;
						end
						`OP_CLIP: begin
							clip_en_nxt = cmd_word[`FLAG_BIT];
							state_nxt = ST_FIXED;
							tmr_nxt = `CLIP_CYC - 9'h002;
							ld_c = 1'b1;
						end
						`OP_COPY, `OP_COPY_CUR: state_nxt = ST_PARAM;
						default: ;
					endcase
				end
			end
			ST_PARAM: begin
				if (cmd_valid) begin
					cmd_take = 1'b1;
					par_nxt[pidx_r] = cmd_word;
					pidx_nxt = 2'(pidx_r + 2'h1);
					if (pidx_r == last_c) begin
						state_nxt = ST_SETUP;
						tmr_nxt = setup_c - 9'h001;
						ld_c = 1'b1;
					end
				end
			end
			ST_FIXED: begin
				if (tmr_r == 9'h000) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_SETUP: begin
				if (tmr_r == 9'h000) begin
					src_x_nxt = rsx_c;
					src_y_nxt = rsy_c;
					dst_x_nxt = rdx_c;
					dst_y_nxt = rdy_c;
					row_nxt = 11'h000;
					state_nxt = ST_LINE;
					tmr_nxt = line_c - 9'h001;
					ld_c = 1'b1;
				end
			end
			ST_LINE: begin
				if (tmr_r == 9'h000) begin
					if (bw_c == 11'h000 || bh_c == 11'h000) begin
						done_c = 1'b1;
					end else begin
						wd_nxt = wstart_c;
						state_nxt = ST_WORD;
						step_nxt = 3'h0;
						tmr_nxt = word_c - 9'h001;
						ld_c = 1'b1;
					end
				end
			end
			ST_WORD: begin
				// Reads of both source words and destination precede the write
				case (step_r)
					3'h0: begin
						mem_re_nxt = 1'b1;
						mem_addr_nxt = {srow_c[9:0], swa_c[5:0]};
					end
					3'h1: begin
						mem_re_nxt = 1'b1;
						mem_addr_nxt = {srow_c[9:0], 6'(swa_c[5:0] + 6'h01)};
					end
					3'h2: begin
						mem_re_nxt = 1'b1;
						mem_addr_nxt = {drow_c[9:0], wd_r[5:0]};
						srca_nxt = mem_rdata_i;
					end
					3'h3: srcb_nxt = mem_rdata_i;
					3'h4: begin
						mem_wdata_nxt = comb_res_c;
						mem_wmask_nxt = mask_c;
						mem_we_nxt = !pick_en_r;
					end
					default: ;
				endcase
				if (tmr_r == 9'h000) begin
					if (wd_r != wstop_c) begin
						wd_nxt = rtl_c ? 12'(wd_r - 12'h001) : 12'(wd_r + 12'h001);
						step_nxt = 3'h0;
						tmr_nxt = word_c - 9'h001;
						ld_c = 1'b1;
					end else if (row_r != 11'(bh_c - 11'h001)) begin
						row_nxt = 11'(row_r + 11'h001);
						state_nxt = ST_LINE;
						tmr_nxt = line_c - 9'h001;
						ld_c = 1'b1;
					end else begin
						done_c = 1'b1;
					end
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		// back to idle only when finished
		if (done_c) begin
			state_nxt = ST_IDLE;
		end
		pcnt_nxt = ld_c ? 9'h000 : 9'(pcnt_r + 9'h001);
	end

	// pen to source after full copy
	assign pen_ld_c = done_c && is_full_c;

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			instr_r <= 16'h0000;
			for (int k = 0; k < 4; k++) begin
				par_r[k] <= 16'h0000;
			end
			pidx_r <= 2'h0;
			src_x_r <= 16'h0000;
			src_y_r <= 16'h0000;
			dst_x_r <= 16'h0000;
			dst_y_r <= 16'h0000;
			row_r <= 11'h000;
			wd_r <= 12'h000;
			tmr_r <= 9'h000;
			pcnt_r <= 9'h000;
			step_r <= 3'h0;
			srca_r <= 64'h0000000000000000;
			srcb_r <= 64'h0000000000000000;
			mem_re_r <= 1'b0;
			mem_we_r <= 1'b0;
			mem_addr_r <= 16'h0000;
			mem_wdata_r <= 64'h0000000000000000;
			mem_wmask_r <= 64'h0000000000000000;
			pick_en_r <= 1'b0;
			clip_en_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			instr_r <= instr_nxt;
			par_r <= par_nxt;
			pidx_r <= pidx_nxt;
			src_x_r <= src_x_nxt;
			src_y_r <= src_y_nxt;
			dst_x_r <= dst_x_nxt;
			dst_y_r <= dst_y_nxt;
			row_r <= row_nxt;
			wd_r <= wd_nxt;
			tmr_r <= tmr_nxt;
			pcnt_r <= pcnt_nxt;
			step_r <= step_nxt;
			srca_r <= srca_nxt;
			srcb_r <= srcb_nxt;
			mem_re_r <= mem_re_nxt;
			mem_we_r <= mem_we_nxt;
			mem_addr_r <= mem_addr_nxt;
			mem_wdata_r <= mem_wdata_nxt;
			mem_wmask_r <= mem_wmask_nxt;
			pick_en_r <= pick_en_nxt;
			clip_en_r <= clip_en_nxt;
		end
	end

	// Output drive
	assign s_axi_bvalid_o = bvalid_r;
	assign s_axi_bresp_o = bresp_r;
	assign s_axi_rvalid_o = rvalid_r;
	assign s_axi_rdata_o = rdata_r;
	assign s_axi_rresp_o = rresp_r;
	assign mem_re_o = mem_re_r;
	assign mem_we_o = mem_we_r;
	assign mem_addr_o = mem_addr_r;
	assign mem_wdata_o = mem_wdata_r;
	assign mem_wmask_o = mem_wmask_r;
	assign pick_enable_o = pick_en_r;
	assign clip_enable_o = clip_en_r;

	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n);

	sequence s_three_reads;
		mem_re_r [*3];
	endsequence
	sequence s_then_write;
		##2 (mem_we_r || pick_en_r);
	endsequence

	a_pick_sets_flag: assert property ((state_r == ST_IDLE && cmd_take && cmd_word[6:0] == `OP_PICK)
		|=> pick_en_r == $past(cmd_word[7]) && pen_x_r == $past(pen_x_r))
		else $error("pick flag not taken from instruction");
	a_pick_forty: assert property ((state_r == ST_FIXED && tmr_r == 9'h000 &&
		instr_r[6:0] == `OP_PICK) |-> pcnt_r == 9'h026)
		else $error("pick instruction length wrong");
	a_pick_no_write: assert property (mem_we_r |-> !$past(pick_en_r))
		else $error("display write while picking");
	a_clip_sets_flag: assert property ((state_r == ST_IDLE && cmd_take && cmd_word[6:0] == `OP_CLIP)
		|=> clip_en_r == $past(cmd_word[7]))
		else $error("clip flag not taken from instruction");
	a_setup_time: assert property ((state_r == ST_SETUP && tmr_r == 9'h000)
		|-> pcnt_r == 9'(setup_c - 9'h001))
		else $error("copy setup length wrong");
	a_word_time: assert property ((state_r == ST_WORD && tmr_r == 9'h000)
		|-> pcnt_r == 9'(word_c - 9'h001))
		else $error("destination word length wrong");
	a_word_steps: assert property ((state_r == ST_WORD && step_r == 3'h0)
		|=> s_three_reads ##0 s_then_write)
		else $error("word reads and write out of order");
	a_pen_to_source: assert property (pen_ld_c |=> pen_x_r == $past(src_x_r) &&
		pen_y_r == $past(src_y_r))
		else $error("pen not moved to source");
	a_pen_kept_cur: assert property ((busy && !pen_ld_c) |=> $stable(pen_x_r) && $stable(pen_y_r))
		else $error("pen moved during instruction");
	a_param_order: assert property ((state_r == ST_PARAM && cmd_take)
		|=> pidx_r == 2'($past(pidx_r) + 2'h1))
		else $error("parameter fetch out of order");
	a_set_passes_src: assert property ((instr_r[10:8] == 3'h5) |-> comb_res_c == src_eff_c)
		else $error("set operation altered source");
	a_write_in_word: assert property (mem_we_r |-> state_r == ST_WORD)
		else $error("write outside copy word phase");

endmodule : pick_copy_exec

// *** verif/display_mem_model.sv ***
`timescale 1ns/10ps
module display_mem_model (
	input wire logic ref_clk_i,
	input wire logic re_i,
	input wire logic we_i,
	input wire logic [15:0] addr_i,
	input wire logic [63:0] wdata_i,
	input wire logic [63:0] wmask_i,
	output logic [63:0] rdata_o
);
	logic [63:0] ram [0:65535];
	initial rdata_o = 64'h0;
	// Read data one cycle after strobe; idle data toggles
	always @(posedge ref_clk_i) begin
		if (re_i) rdata_o <= ram[addr_i];
		else rdata_o <= ~rdata_o;
		if (we_i) ram[addr_i] <= (ram[addr_i] & ~wmask_i) | (wdata_i & wmask_i);
	end
endmodule : display_mem_model

// *** verif/pick_control_and_block_copy_test.sv ***
`timescale 1ns/10ps
module pick_control_and_block_copy_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] awaddr = 5'h00;
	logic [4:0] araddr = 5'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, mre, mwe, pick_on, clip_on;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] maddr;
	logic [63:0] mwdata, mwmask, mrdata;
	logic [33:0] rd_q [$];
	logic [143:0] wr_q [$];
	logic [143:0] wexp;
	int fails = 0;
	int total_checks = 0;
	int cyc = 0;
	int bcyc = 0;
	int t0 = 0;
	integer seed = 32'hC865;
	logic pick_now = 1'b0;

	pick_copy_exec uut (.ref_clk_i(clk), .rst_n_i(rst_n),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .mem_re_o(mre), .mem_we_o(mwe),
		.mem_addr_o(maddr), .mem_wdata_o(mwdata), .mem_wmask_o(mwmask),
		.mem_rdata_i(mrdata), .pick_enable_o(pick_on), .clip_enable_o(clip_on));

	display_mem_model mem (.ref_clk_i(clk), .re_i(mre), .we_i(mwe), .addr_i(maddr),
		.wdata_i(mwdata), .wmask_i(mwmask), .rdata_o(mrdata));

	// Clock and cycle count
	always #10 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test();
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test

	// Bus write, both channels offered together
	task automatic axw(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		bcyc = cyc;
		chk(80'(bresp), 80'h0);
	endtask : axw

	// Bus read, expected answer queued
	task automatic axr(input logic [4:0] a, input logic [33:0] e);
		@(posedge clk);
		rd_q.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask : axr

	function automatic logic [63:0] cmb(input logic [2:0] op, input logic [63:0] s,
		input logic [63:0] d);
		case (op)
			3'h0: cmb = 64'h0;
			3'h1: cmb = s & d;
			3'h2: cmb = s | d;
			3'h3: cmb = s ^ d;
			3'h4: cmb = d;
			3'h5: cmb = s;
			3'h6: cmb = ~s & d;
			default: cmb = {64{1'b1}};
		endcase
	endfunction : cmb

	// One-word copy: source word 322, destination word 387
	task automatic copy(input logic [15:0] w, input logic [15:0] sx, input logic [15:0] sy);
		logic [63:0] s;
		logic [63:0] d;
		logic [63:0] m;
		s = {$random(seed), $random(seed)};
		d = {$random(seed), $random(seed)};
		mem.ram[322] = s;
		mem.ram[323] = {$random(seed), $random(seed)};
		mem.ram[387] = d;
		if (w[14]) s = ~s;
		if (w[15]) s = {4{s[15:0]}};
		// Colour match keeps only pixels of search colour zero
		m = {64{1'b1}};
		for (int i = 0; i < 16; i++)
			if (w[13] && {d[48+i], d[32+i], d[16+i], d[i]} != 4'h0)
				m = m & ~(64'h0001000100010001 << i);
		if (!pick_now) wr_q.push_back({16'd387, cmb(w[10:8], s, d) & m, m});
		axw(5'h00, {16'h0, w});
		if (w[6]) begin
			axw(5'h00, {16'h0, sx});
			axw(5'h00, {16'h0, sy});
		end
		axw(5'h00, 32'h8010);
		axw(5'h00, 32'h0001);
		t0 = bcyc;
		axw(5'h00, 32'h007F);
		// Last parameter's own fetch cycle precedes setup
		chk(80'(bcyc - t0), 80'(1 + (w[6] ? 218 : 166)
			+ (w[15] ? 42 : (w[14] | w[13]) ? 40 : 36)
			+ (w[13] ? 276 : w[14] ? 30 : w[15] ? 25 : 19)));
	endtask : copy

	// Results compared against oldest note
	always @(posedge clk) begin
		if (rvalid && rready) begin
			if (rd_q.size() == 0) chk(80'h1, 80'h0);
			else chk({46'h0, rresp, rdata}, {46'h0, rd_q.pop_front()});
		end
		if (mwe) begin
			if (wr_q.size() == 0) chk(80'h1, 80'h0);
			else begin
				wexp = wr_q.pop_front();
				chk({maddr, mwdata & mwmask}, wexp[143:64]);
				chk({16'h0, mwmask}, {16'h0, wexp[63:0]});
			end
		end
	end

	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		axr(5'h10, {2'b00, 32'h000F0000});
		axr(5'h08, 34'h0);
		axr(5'h0C, 34'h0);
		axr(5'h14, {2'b10, 32'h0});
		axw(5'h08, 32'h00040010);
		axw(5'h0C, 32'h00010010);
		axr(5'h0C, {2'b00, 32'h00010010});
		copy(16'h055C, 16'h8010, 16'h0001);
		axr(5'h08, {2'b00, 32'h00050020});
		for (int i = 0; i < 8; i++)
			copy(16'h001C | (16'(i) << 8) | (i[0] ? 16'h4000 : 16'h0)
				| (i == 6 ? 16'h8000 : 16'h0) | (i == 2 ? 16'h0040 : 16'h0),
				16'h0020, 16'h0005);
		copy(16'h251C, 16'h0020, 16'h0005);
		axr(5'h08, {2'b00, 32'h00050020});
		axw(5'h00, 32'h00B5);
		t0 = bcyc;
		axw(5'h00, 32'h00B4);
		chk(80'(bcyc - t0), 80'd40);
		pick_now = 1'b1;
		copy(16'h055C, 16'h0020, 16'h0005);
		axr(5'h04, {2'b00, 32'h00000006});
		chk(80'({pick_on, clip_on}), 80'h3);
		axw(5'h00, 32'h0035);
		axw(5'h00, 32'h0034);
		axw(5'h00, 32'h007F);
		repeat (3) @(posedge clk);
		axr(5'h04, 34'h0);
		chk(80'({pick_on, clip_on}), 80'h0);
		axr(5'h08, {2'b00, 32'h00050020});
		repeat (4) @(posedge clk);
		chk(80'(rd_q.size() + wr_q.size()), 80'h0);
		end_of_test();
	end

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		end_of_test();
	end
endmodule : pick_control_and_block_copy_test
